// file: verilog/clp_regs.svh
`ifndef CLP_REGS_SVH
`define CLP_REGS_SVH
// Register byte offsets within the APB window
`define CLP_OFS_CTRL       12'h000
`define CLP_OFS_TIMING     12'h004
`define CLP_OFS_STATUS     12'h008
`define CLP_OFS_BUSOFF     12'h00c
// Control register field positions
`define CLP_CTRL_SLEEP_REQ 0
`define CLP_CTRL_SOFT_RST  1
`define CLP_CTRL_TLINK     2
`define CLP_CTRL_WAKE_FILT 3
`define CLP_CTRL_CLK_SRC   4
`define CLP_CTRL_WAKE_IE   5
`define CLP_CTRL_STOP_WAI  6
`define CLP_CTRL_RESET     32'h0000_0002
// Timing register fields: prescale-1 [5:0], seg1-1 [11:8], seg2-1 [14:12], jump-1 [17:16]
`define CLP_TIM_RESET      32'h0000_1300
// Bus-off recovery: 128 groups of 11 recessive bits
`define CLP_BOFF_GROUPS    8'd128
`define CLP_BOFF_BITS      4'd11
`define CLP_IDLE_BITS      4'd11
// Wake filter length in controller clocks
`define CLP_WAKE_FILT_CYC  4'd8
`endif

// file: verilog/clp_pkg.sv
package clp_pkg;
    // Mode codes in Gray order; sequence normal -> sleep -> wake-wait -> normal
    typedef enum logic [1:0]
    {
        CLP_NORMAL = 2'b00,
        CLP_SLEEP  = 2'b01,
        CLP_WAKE   = 2'b11,
        CLP_SRST   = 2'b10
    } clp_mode_t;

    typedef struct packed
    {
        clp_mode_t   mode;
        logic [31:0] ctrl;
        logic [31:0] timing;
        logic [31:0] prdata;
        logic        pready;
        logic [5:0]  presc;
        logic [4:0]  quanta;
        logic        tq_pend;
        logic [3:0]  rec_cnt;
        logic [3:0]  boff_bits;
        logic [7:0]  boff_grp;
        logic [3:0]  filt_cnt;
        logic        pend_copy;
        logic        pend_abort;
        logic [3:0]  eof_cnt;
        logic        link;
        logic        link_arm;
        logic        tx_q;
    } clp_state_t;
endpackage : clp_pkg

// file: verilog/clp_core.sv
`timescale 1ns/1ps
`include "clp_regs.svh"
module clp_core
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Processor low-power state
    input  wire logic        cpu_stop,
    input  wire logic        cpu_wait,
    // Clock ticks: crystal and double system clock, one-cycle enables
    input  wire logic        crystal_clock,
    input  wire logic        bus_clock,
    // CAN pins and protocol engine hooks
    input  wire logic        bus_receive_pin,
    input  wire logic        engine_tx,
    input  wire logic        engine_busy,
    input  wire logic        bus_off,
    input  wire logic        frame_valid,
    input  wire logic        copy_req,
    input  wire logic        abort_req,
    output logic             bus_transmit_pin,
    output logic             quantum_tick,
    output logic             bit_tick,
    output logic             protocol_run,
    output logic             engine_abort,
    output logic             copy_go,
    output logic             abort_go,
    output logic             boff_done,
    output logic             timer_capture,
    output logic             wake_irq
);

    clp_pkg::clp_state_t s_q;
    clp_pkg::clp_state_t s_d;

    logic        power_down;
    logic        acc;
    logic        sleep_ack;
    logic        src_tick;
    logic [4:0]  bit_len;
    logic        bit_end;
    logic        rx_quiet;
    logic        wake_ev;
    logic        proto_en;

    // Power-down when stopped, or waiting with stop_in_wait set
    assign power_down = cpu_stop | (cpu_wait & s_q.ctrl[`CLP_CTRL_STOP_WAI]);
    assign acc        = psel & penable & ~power_down;
    assign sleep_ack  = (s_q.mode == clp_pkg::CLP_SLEEP);
    // Clock source selection; both are pclk-synchronous tick inputs
    assign src_tick   = s_q.ctrl[`CLP_CTRL_CLK_SRC] ? bus_clock : crystal_clock;
    // Bit length: sync slot + (seg1-1)+1 + (seg2-1)+1
    assign bit_len    = 5'd3 + {1'b0, s_q.timing[11:8]} + {2'b00, s_q.timing[14:12]};
    assign proto_en   = (s_q.mode == clp_pkg::CLP_NORMAL || s_q.mode == clp_pkg::CLP_WAKE)
                        & ~power_down;
    assign bit_end    = s_q.tq_pend & (s_q.quanta == bit_len - 5'd1);
    // Low-pass: receive must stay dominant for a run of clocks when enabled
    assign rx_quiet   = bus_receive_pin;
    assign wake_ev    = s_q.ctrl[`CLP_CTRL_WAKE_FILT] ?
                        (s_q.filt_cnt == `CLP_WAKE_FILT_CYC) : ~rx_quiet;

    // Next-state logic
    always_comb
    begin
        s_d        = s_q;
        s_d.pready = 1'b0;
        s_d.tq_pend = 1'b0;

        // Register access: one wait cycle, no access during power-down
        if (acc && !s_q.pready)
        begin
            s_d.pready = 1'b1;
            if (pwrite)
            begin
                if (paddr == `CLP_OFS_CTRL)
                begin
                    s_d.ctrl = pwdata & 32'h0000_007f;
                    // Clear of sleep request refused before acknowledge
                    if (!pwdata[`CLP_CTRL_SLEEP_REQ] && !sleep_ack)
                        s_d.ctrl[`CLP_CTRL_SLEEP_REQ] = s_q.ctrl[`CLP_CTRL_SLEEP_REQ];
                    // Config bits locked unless in soft reset
                    if (!s_q.ctrl[`CLP_CTRL_SOFT_RST])
                    begin
                        s_d.ctrl[`CLP_CTRL_WAKE_FILT] = s_q.ctrl[`CLP_CTRL_WAKE_FILT];
                        s_d.ctrl[`CLP_CTRL_CLK_SRC]   = s_q.ctrl[`CLP_CTRL_CLK_SRC];
                    end
                end
                else if (paddr == `CLP_OFS_TIMING && s_q.ctrl[`CLP_CTRL_SOFT_RST])
                    s_d.timing = pwdata & 32'h0003_7f3f;
            end
            else
            begin
                if (paddr == `CLP_OFS_CTRL)
                    s_d.prdata = s_q.ctrl;
                else if (paddr == `CLP_OFS_TIMING)
                    s_d.prdata = s_q.timing;
                else if (paddr == `CLP_OFS_STATUS)
                    s_d.prdata = {26'h0, s_q.pend_abort, s_q.pend_copy,
                                  s_q.mode, wake_irq, sleep_ack};
                else if (paddr == `CLP_OFS_BUSOFF)
                    s_d.prdata = {20'h0, s_q.boff_bits, s_q.boff_grp};
                else
                    s_d.prdata = 32'h0;
            end
        end

        // Prescaler: divide selected clock by (field+1)
        if (proto_en && src_tick)
        begin
            if (s_q.presc == s_q.timing[5:0])
            begin
                s_d.presc   = 6'h00;
                s_d.tq_pend = 1'b1;
            end
            else
                s_d.presc = s_q.presc + 6'h01;
        end
        // Quantum counter within bit time
        if (s_q.tq_pend)
            s_d.quanta = bit_end ? 5'h00 : s_q.quanta + 5'h01;

        // Deferred events held while sleeping
        if (copy_req)
            s_d.pend_copy = 1'b1;
        if (abort_req)
            s_d.pend_abort = 1'b1;
        if (s_q.mode == clp_pkg::CLP_NORMAL)
        begin
            s_d.pend_copy  = copy_req ? s_q.pend_copy : 1'b0;
            s_d.pend_abort = abort_req ? s_q.pend_abort : 1'b0;
        end

        // Bus-off recovery count, frozen while clocks stopped
        if (!bus_off)
        begin
            s_d.boff_bits = 4'h0;
            s_d.boff_grp  = 8'h00;
        end
        else if (bit_end && rx_quiet && s_q.boff_grp != `CLP_BOFF_GROUPS)
        begin
            if (s_q.boff_bits == `CLP_BOFF_BITS - 4'd1)
            begin
                s_d.boff_bits = 4'h0;
                s_d.boff_grp  = s_q.boff_grp + 8'h01;
            end
            else
                s_d.boff_bits = s_q.boff_bits + 4'h1;
        end
        else if (bit_end && !rx_quiet)
            s_d.boff_bits = 4'h0;

        // Wake filter run length of dominant receive level
        if (!rx_quiet && s_q.filt_cnt != `CLP_WAKE_FILT_CYC)
            s_d.filt_cnt = s_q.filt_cnt + 4'h1;
        else if (rx_quiet)
            s_d.filt_cnt = 4'h0;

        // Mode sequencing
        case (s_q.mode)
            clp_pkg::CLP_NORMAL:
            begin
                if (s_q.ctrl[`CLP_CTRL_SOFT_RST])
                    s_d.mode = clp_pkg::CLP_SRST;
                else if (s_q.ctrl[`CLP_CTRL_SLEEP_REQ] && !engine_busy)
                    s_d.mode = clp_pkg::CLP_SLEEP;
            end
            clp_pkg::CLP_SLEEP:
            begin
                if (wake_ev || !s_q.ctrl[`CLP_CTRL_SLEEP_REQ] ||
                    s_q.ctrl[`CLP_CTRL_SOFT_RST])
                begin
                    s_d.mode    = clp_pkg::CLP_WAKE;
                    s_d.rec_cnt = 4'h0;
                    s_d.ctrl[`CLP_CTRL_SLEEP_REQ] = 1'b0;
                end
            end
            clp_pkg::CLP_WAKE:
            begin
                if (s_q.ctrl[`CLP_CTRL_SOFT_RST])
                    s_d.mode = clp_pkg::CLP_SRST;
                else if (bit_end)
                begin
                    s_d.rec_cnt = rx_quiet ? s_q.rec_cnt + 4'h1 : 4'h0;
                    if (rx_quiet && s_q.rec_cnt == `CLP_IDLE_BITS - 4'd1)
                        s_d.mode = clp_pkg::CLP_NORMAL;
                end
            end
            default:
            begin
                if (!s_q.ctrl[`CLP_CTRL_SOFT_RST])
                begin
                    s_d.mode    = clp_pkg::CLP_WAKE;
                    s_d.rec_cnt = 4'h0;
                end
            end
        endcase

        // Soft reset parks the bit clock so new timing starts from slot zero
        if (s_d.mode == clp_pkg::CLP_SRST)
        begin
            s_d.presc   = 6'h00;
            s_d.quanta  = 5'h00;
            s_d.tq_pend = 1'b0;
        end

        // Valid-frame pulse lasts one bit time
        if (frame_valid && proto_en)
            s_d.link_arm = 1'b1;
        if (s_q.link_arm && bit_end)
        begin
            s_d.link_arm = 1'b0;
            s_d.link     = 1'b1;
        end
        else if (s_q.link && bit_end)
            s_d.link = 1'b0;
        if (!proto_en)
        begin
            s_d.link     = 1'b0;
            s_d.link_arm = 1'b0;
        end

        // Transmit pin from flop; recessive when protocol halted
        s_d.tx_q = proto_en && s_q.mode == clp_pkg::CLP_NORMAL ? engine_tx : 1'b1;
        s_d.eof_cnt = 4'h0;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q        <= '0;
            s_q.mode   <= clp_pkg::CLP_SRST;
            s_q.ctrl   <= `CLP_CTRL_RESET;
            s_q.timing <= `CLP_TIM_RESET;
            s_q.tx_q   <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // Outputs
    assign pready           = s_q.pready;
    assign prdata           = s_q.prdata;
    assign pslverr          = 1'b0;
    assign bus_transmit_pin = s_q.tx_q;
    assign quantum_tick     = s_q.tq_pend;
    assign bit_tick         = bit_end;
    assign protocol_run     = proto_en;
    assign engine_abort     = s_q.ctrl[`CLP_CTRL_SOFT_RST] | power_down;
    assign copy_go          = s_q.pend_copy & (s_q.mode == clp_pkg::CLP_NORMAL);
    assign abort_go         = s_q.pend_abort & (s_q.mode == clp_pkg::CLP_NORMAL);
    assign boff_done        = (s_q.boff_grp == `CLP_BOFF_GROUPS);
    assign timer_capture    = s_q.link & s_q.ctrl[`CLP_CTRL_TLINK];
    assign wake_irq         = sleep_ack & s_q.ctrl[`CLP_CTRL_WAKE_IE];

    a_tx_recessive_low: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.mode == clp_pkg::CLP_SLEEP) |=> bus_transmit_pin)
        else $error("Transmit pin not recessive in sleep");
    a_no_copy_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_ack |-> !copy_go)
        else $error("Copy released during sleep");
    a_no_abort_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_ack |-> !abort_go)
        else $error("Abort released during sleep");
    a_req_clear_held: assert property (@(posedge pclk) disable iff (!presetn)
        (!sleep_ack && $past(s_q.mode) != clp_pkg::CLP_SLEEP &&
         $past(s_q.ctrl[`CLP_CTRL_SLEEP_REQ])) |-> s_q.ctrl[`CLP_CTRL_SLEEP_REQ])
        else $error("Sleep request cleared before acknowledge");
    a_no_access_pd: assert property (@(posedge pclk) disable iff (!presetn)
        (power_down && !s_q.pready) |=> !pready)
        else $error("Register answered in power-down");
    a_link_gated: assert property (@(posedge pclk) disable iff (!presetn)
        timer_capture |-> (s_q.link && s_q.ctrl[`CLP_CTRL_TLINK]))
        else $error("Timer capture without link enable");
    a_wake_irq_cond: assert property (@(posedge pclk) disable iff (!presetn)
        wake_irq |-> (s_q.mode == clp_pkg::CLP_SLEEP))
        else $error("Wake interrupt outside sleep");
    a_srst_halts: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.mode == clp_pkg::CLP_SRST) |-> (!protocol_run && !quantum_tick ##1 !quantum_tick))
        else $error("Protocol runs in soft reset");
    a_sleep_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_ack ##1 sleep_ack) |-> $stable(s_q.boff_grp))
        else $error("Bus-off count moved in sleep");

    // Quanta stay stopped once sleep has settled
    a_sleep_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_ack ##1 sleep_ack) |-> !quantum_tick)
        else $error("Quantum tick while sleeping");

    // Power-down forces the transmit pin recessive on the next edge
    a_pd_recessive: assert property (@(posedge pclk) disable iff (!presetn)
        power_down |=> bus_transmit_pin)
        else $error("Transmit pin dominant in power-down");

    // Stop, or wait with stop_in_wait, must abort the engine at once
    a_pd_abort: assert property (@(posedge pclk) disable iff (!presetn)
        (cpu_stop || (cpu_wait && s_q.ctrl[`CLP_CTRL_STOP_WAI])) |-> engine_abort)
        else $error("Power-down without engine abort");

    // Soft reset aborts without waiting for a frame boundary
    a_srst_abort: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.ctrl[`CLP_CTRL_SOFT_RST] |-> engine_abort)
        else $error("Soft reset without engine abort");

    // Link pulse starts on a bit boundary
    a_link_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_q.link) |-> $past(bit_end))
        else $error("Link pulse started off a bit boundary");

    // Link pulse ends on a bit boundary or when the protocol halts
    a_link_end: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(s_q.link) |-> ($past(bit_end) || !$past(proto_en)))
        else $error("Link pulse ended off a bit boundary");

    // Wake-up restarts the idle count and drops the request
    a_wake_clears: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(s_q.mode) == clp_pkg::CLP_SLEEP && s_q.mode == clp_pkg::CLP_WAKE) |->
        (s_q.rec_cnt == 4'h0 && !s_q.ctrl[`CLP_CTRL_SLEEP_REQ]))
        else $error("Wake-up did not restart idle count");

    // Normal mode only after the full run of recessive bits
    a_idle_before_run: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(s_q.mode) == clp_pkg::CLP_WAKE && s_q.mode == clp_pkg::CLP_NORMAL) |->
        ($past(s_q.rec_cnt) == `CLP_IDLE_BITS - 4'd1))
        else $error("Normal mode before idle bits counted");

    // Bit timing may only change while soft reset holds the lock open
    a_timing_locked: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.ctrl[`CLP_CTRL_SOFT_RST] |=> $stable(s_q.timing))
        else $error("Timing changed outside soft reset");

    // Every quantum comes from a tick of the selected source
    a_tick_from_src: assert property (@(posedge pclk) disable iff (!presetn)
        quantum_tick |-> $past(src_tick))
        else $error("Quantum without source tick");

    // Unfiltered dominant level wakes the controller on the next edge
    a_wake_on_bus: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_ack && !s_q.ctrl[`CLP_CTRL_WAKE_FILT] && !bus_receive_pin) |=> !sleep_ack)
        else $error("Bus activity did not wake");

endmodule : clp_core

// file: verification/clp_bus_model.sv
`timescale 1ns/1ps
module clp_bus_model
(
    // Clock, reset and remote-node trigger
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       dom_go,
    input  wire logic [7:0] dom_len,
    // Bus lines
    input  wire logic       bus_transmit_pin,
    output logic            bus_receive_pin
);
    logic [7:0] dom_q;

    // Remote node holds the bus dominant for dom_len clocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dom_q <= 8'h00;
        else if (dom_go)
            dom_q <= dom_len;
        else if (dom_q != 8'h00)
            dom_q <= dom_q - 8'h01;
    end

    // Wired-AND bus: our own transmitter is heard back as well
    assign bus_receive_pin = bus_transmit_pin & (dom_q == 8'h00);
endmodule : clp_bus_model

// file: verification/can_lowpower_bit_timing_bench.sv
`timescale 1ns/1ps
`include "clp_regs.svh"
module can_lowpower_bit_timing_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, boff, bdone;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        cpu_stop, cpu_wait, crystal_clock, bus_clock, rx, engine_tx, engine_busy;
    logic        frame_valid, copy_req, abort_req, tx, qtick, bit_tick, run, eabort;
    logic        copy_go, abort_go, cap, wake_irq, dom_go;
    logic [7:0]  dom_len;
    logic [1:0]  cyc;
    int          errors, checks_done, n;

    clp_core u_clp_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
        .crystal_clock(crystal_clock), .bus_clock(bus_clock), .bus_receive_pin(rx),
        .engine_tx(engine_tx), .engine_busy(engine_busy), .bus_off(boff),
        .frame_valid(frame_valid), .copy_req(copy_req), .abort_req(abort_req),
        .bus_transmit_pin(tx), .quantum_tick(qtick), .bit_tick(bit_tick),
        .protocol_run(run), .engine_abort(eabort), .copy_go(copy_go),
        .abort_go(abort_go), .boff_done(bdone), .timer_capture(cap), .wake_irq(wake_irq));

    clp_bus_model u_clp_bus_model (.pclk(pclk), .presetn(presetn), .dom_go(dom_go),
        .dom_len(dom_len), .bus_transmit_pin(tx), .bus_receive_pin(rx));

    // 40 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Source ticks: double clock every 2nd cycle, crystal every 4th
    always @(posedge pclk)
    begin
        cyc <= cyc + 2'd1;
        bus_clock <= cyc[0];
        crystal_clock <= (cyc == 2'd3);
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task tally_and_finish;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // One APB transfer; only the watchdog ends a wait for pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_ack(input logic v);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, `CLP_OFS_STATUS, 32'h0);
            k++;
        end
        while (rd[0] !== v && k < 60);
    endtask : wait_ack

    task wait_run;
        n = 0;
        while (run !== 1'b1 && n < 800)
        begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_run

    // Cycles between two bit ticks
    task bit_len(input int exp, input int expq);
        int q;
        wait_run();
        @(posedge pclk);
        while (bit_tick !== 1'b1) @(posedge pclk);
        n = 0;
        q = 0;
        do
        begin
            @(posedge pclk);
            n++;
            q += (qtick === 1'b1);
        end
        while (bit_tick !== 1'b1 && n < 400);
        chk(32'(n), 32'(exp));
        chk(32'(q), 32'(expq));
    endtask : bit_len

    task t_reset;
        apb(1'b0, `CLP_OFS_CTRL, 32'h0);
        chk(rd, `CLP_CTRL_RESET);
        apb(1'b0, `CLP_OFS_TIMING, 32'h0);
        chk(rd, `CLP_TIM_RESET);
        apb(1'b0, 12'h040, 32'h0);
        chk(rd, 32'h0);
        chk(32'(tx), 32'h1);
        chk(32'(pslverr), 32'h0);
    endtask : t_reset

    // Crystal with prescale 2 and longest segment two, then double clock
    task t_timing;
        logic [31:0] cv [2];
        logic [31:0] tv [2];
        int ev [2];
        int eq [2];
        cv = '{32'h02, 32'h12};
        tv = '{32'h0000_7701, 32'h0003_1300};
        ev = '{136, 14};
        eq = '{17, 7};
        for (int i = 0; i < 2; i++)
        begin
            // Clock source is locked until soft reset is already in force
            apb(1'b1, `CLP_OFS_CTRL, 32'h2);
            apb(1'b1, `CLP_OFS_CTRL, cv[i]);
            apb(1'b1, `CLP_OFS_TIMING, tv[i]);
            apb(1'b0, `CLP_OFS_TIMING, 32'h0);
            chk(rd, tv[i]);
            apb(1'b1, `CLP_OFS_CTRL, cv[i] & ~32'h2);
            bit_len(ev[i], eq[i]);
            apb(1'b1, `CLP_OFS_TIMING, 32'h0);
            apb(1'b0, `CLP_OFS_TIMING, 32'h0);
            chk(rd, tv[i]);
        end
    endtask : t_timing

    task t_sleep;
        logic [31:0] s1;
        wait_run();
        boff <= 1'b1;
        apb(1'b1, `CLP_OFS_CTRL, 32'h31);
        wait_ack(1'b1);
        chk(32'(rd[0]), 32'h1);
        chk(32'(wake_irq), 32'h1);
        chk({30'h0, tx, run}, 32'h2);
        apb(1'b0, `CLP_OFS_BUSOFF, 32'h0);
        s1 = rd;
        @(posedge pclk);
        copy_req <= 1'b1;
        abort_req <= 1'b1;
        @(posedge pclk);
        copy_req <= 1'b0;
        abort_req <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({30'h0, copy_go, abort_go}, 32'h0);
        apb(1'b0, `CLP_OFS_BUSOFF, 32'h0);
        chk(rd, s1);
        apb(1'b1, `CLP_OFS_CTRL, 32'h30);
        wait_ack(1'b0);
        chk(32'(rd[0]), 32'h0);
        chk(32'(wake_irq), 32'h0);
        n = 0;
        while (copy_go !== 1'b1 && n < 600)
        begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n > 120), 32'h1);
        chk({30'h0, copy_go, abort_go}, 32'h3);
        apb(1'b0, `CLP_OFS_BUSOFF, 32'h0);
        chk(32'(rd != s1), 32'h1);
        n = 0;
        while (bdone !== 1'b1 && n < 25000)
        begin
            @(posedge pclk);
            n++;
        end
        apb(1'b0, `CLP_OFS_BUSOFF, 32'h0);
        chk(rd, 32'h80);
        chk(32'(bdone), 32'h1);
        boff <= 1'b0;
    endtask : t_sleep

    task t_filter;
        apb(1'b1, `CLP_OFS_CTRL, 32'h1a);
        apb(1'b1, `CLP_OFS_CTRL, 32'h18);
        wait_run();
        engine_busy <= 1'b1;
        apb(1'b1, `CLP_OFS_CTRL, 32'h19);
        apb(1'b1, `CLP_OFS_CTRL, 32'h18);
        apb(1'b0, `CLP_OFS_CTRL, 32'h0);
        chk(32'(rd[0]), 32'h1);
        engine_busy <= 1'b0;
        wait_ack(1'b1);
        for (int i = 0; i < 2; i++)
        begin
            dom_len <= i ? 8'd20 : 8'd4;
            dom_go <= 1'b1;
            @(posedge pclk);
            dom_go <= 1'b0;
            repeat (30) @(posedge pclk);
            apb(1'b0, `CLP_OFS_STATUS, 32'h0);
            chk(32'(rd[0]), 32'(i == 0));
        end
    endtask : t_filter

    // Software sleeps first, then sets soft reset from sleep
    task t_srst;
        apb(1'b1, `CLP_OFS_CTRL, 32'h11);
        wait_ack(1'b1);
        chk(32'(rd[0]), 32'h1);
        engine_busy <= 1'b1;
        apb(1'b1, `CLP_OFS_CTRL, 32'h13);
        @(negedge pclk);
        chk(32'(eabort), 32'h1);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({30'h0, eabort, run}, 32'h2);
        apb(1'b0, `CLP_OFS_CTRL, 32'h0);
        chk(rd, 32'h1a);
        engine_busy <= 1'b0;
        apb(1'b1, `CLP_OFS_CTRL, 32'h14);
    endtask : t_srst

    // Valid-frame pulse reaches the timer only while linked
    task t_link;
        for (int i = 0; i < 2; i++)
        begin
            wait_run();
            @(posedge pclk);
            frame_valid <= 1'b1;
            @(posedge pclk);
            frame_valid <= 1'b0;
            n = 0;
            repeat (60)
            begin
                @(posedge pclk);
                n += (cap === 1'b1);
            end
            chk(32'(n), (i == 0) ? 32'd14 : 32'd0);
            apb(1'b1, `CLP_OFS_CTRL, 32'h10);
        end
    endtask : t_link

    task t_pdown;
        int k;
        // Wait for normal mode so the engine drives the pin
        do
            apb(1'b0, `CLP_OFS_STATUS, 32'h0);
        while (rd[3:2] !== 2'b00);
        engine_tx <= 1'b0;
        cpu_wait <= 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({30'h0, eabort, tx}, 32'h0);
        apb(1'b1, `CLP_OFS_CTRL, 32'h50);
        @(negedge pclk);
        chk({30'h0, eabort, tx}, 32'h3);
        @(posedge pclk);
        cpu_wait <= 1'b0;
        cpu_stop <= 1'b1;
        psel <= 1'b1;
        pwrite <= 1'b0;
        paddr <= `CLP_OFS_CTRL;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        repeat (8)
        begin
            @(posedge pclk);
            k += (pready === 1'b1);
        end
        chk(32'(k), 32'h0);
        chk(32'(eabort), 32'h1);
        cpu_stop <= 1'b0;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        chk(prdata, 32'h50);
        psel <= 1'b0;
        penable <= 1'b0;
        engine_tx <= 1'b1;
    endtask : t_pdown

    initial
    begin
        {presetn, psel, penable, pwrite, cpu_stop, cpu_wait, copy_req, abort_req} = '0;
        {frame_valid, engine_busy, dom_go, bus_clock, crystal_clock, boff} = '0;
        {paddr, pwdata, dom_len, cyc, errors, checks_done} = '0;
        engine_tx = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_timing();
        t_sleep();
        t_filter();
        t_srst();
        t_link();
        t_pdown();
        tally_and_finish();
    end

    // Watchdog well past the expected run length
    initial
    begin
        #2000000;
        errors++;
        tally_and_finish();
    end
endmodule : can_lowpower_bit_timing_bench
